// ==== hdl/sfx_classifier.sv ====
// Notes on behaviour
// - Alternating add/sub: all flags except divide-by-zero
// - Horizontal add/sub: all flags except divide-by-zero
// - Unaligned load and duplicating moves raise nothing
// - Integer vector extension group raises nothing
// - Round: invalid; precision only if imm bit3 clear
// - Dot product: all flags except divide-by-zero; other fourth-generation instructions raise nothing
`timescale 1ns/100ps
// Exception classifier for decoded floating-point vector instructions.
// The decoder hands over one class code per request, with the
// instruction's immediate byte alongside; the block answers with the
// set of floating-point exception flags that instruction may raise.
// The lookup is combinational, but the mask is registered so that the
// downstream flag-merging logic sees a value steady for a whole cycle.
// Latency is one cycle. mask_valid pulses once per accepted request and
// may stay high for back-to-back requests; flag_mask holds the mask of
// the last accepted request until the next one arrives.
// The immediate only matters for the round-to-integral classes, where
// one bit silences the precision flag; other classes ignore it.
// Codes beyond the last defined class are answered with an empty mask,
// the same as any class that never touches floating-point values.
// Nothing here is ever refused, so there is no back-pressure.
module sfx_classifier
  import sfx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [4:0] op_class,
  input wire logic [7:0] op_imm,
  output logic mask_valid,
  output logic [5:0] flag_mask
);

  // Class code as the enumeration; undefined codes still cast cleanly
  sfx_class_t cls;
  // Combinational mask for the class now presented
  logic [5:0] next_flag_mask;

  // Refuse a package whose widths no longer fit the fixed ports
  if (SFX_FLAG_W != 6 || SFX_CLASS_W != 5 || SFX_IMM_W != 8 ||
      SFX_IMM_SUPPRESS_BIT >= SFX_IMM_W) begin : g_width_check
    $error("Package widths do not fit the classifier ports");
  end

  // Reinterpret the raw code; no decoding happens here
  assign cls = sfx_class_t'(op_class);

  // True for classes that round to integral values
  function automatic logic is_round(input sfx_class_t c);
    begin
      is_round = (c == round_packed_double) ||
                 (c == round_packed_single) ||
                 (c == round_scalar_double) ||
                 (c == round_scalar_single);
    end
  endfunction

  // True for the add/sub style classes that never divide
  function automatic logic is_addsub(input sfx_class_t c);
    begin
      is_addsub = (c == alt_addsub_packed_double) ||
                  (c == alt_addsub_packed_single) ||
                  (c == horiz_add_packed_double) ||
                  (c == horiz_add_packed_single) ||
                  (c == horiz_sub_packed_double) ||
                  (c == horiz_sub_packed_single);
    end
  endfunction

  // True for loads and moves that only shuffle bits
  function automatic logic is_move(input sfx_class_t c);
    begin
      is_move = (c == unaligned_wide_int_load) ||
                (c == double_dup_move) ||
                (c == single_high_dup_move) ||
                (c == single_low_dup_move);
    end
  endfunction

  // True for the dot-product classes, used by the lookup and a check
  function automatic logic is_dot(input sfx_class_t c);
    begin
      is_dot = (c == dot_product_double) ||
               (c == dot_product_single);
    end
  endfunction

  // Class to mask lookup. The classes are disjoint, so the order of the
  // branches only matters for readability; the default of no flags is
  // set first so every path assigns the whole mask.
  always_comb begin
    // Nothing raised unless a branch below says otherwise
    next_flag_mask = SFX_MASK_NONE;
    if (is_addsub(cls)) begin
      // Arithmetic can raise all but divide-by-zero
      next_flag_mask = SFX_MASK_ARITH;
    end else if (is_dot(cls)) begin
      // Dot product multiplies then adds, so it never divides
      next_flag_mask = SFX_MASK_ARITH;
    end else if (is_round(cls)) begin
      // Invalid always possible, precision unless suppressed
      next_flag_mask = SFX_MASK_ROUND;
      // Suppress bit set: rounding stays silent about inexact results
      if (op_imm[SFX_IMM_SUPPRESS_BIT]) begin
        next_flag_mask[SFX_BIT_PRECISION] = 1'b0;
      end
    end else if (is_move(cls)) begin
      // Pure data movement
      next_flag_mask = SFX_MASK_NONE;
    end else if (cls == sfx_int_vector_group) begin
      // Integer-only elements
      next_flag_mask = SFX_MASK_NONE;
    end else begin
      // sfx_other_class, remaining fourth-generation and unknown codes
      next_flag_mask = SFX_MASK_NONE;
    end
  end

  // Output register for the mask; it holds between requests so that a
  // late reader still sees the mask of the last accepted instruction
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Reset clears the mask so nothing is flagged before the first op
      flag_mask <= SFX_MASK_RESET;
    end else if (op_valid) begin
      // Load only on a request; idle cycles keep the old mask
      flag_mask <= next_flag_mask;
    end
  end

  // Valid strobe follows the request by one cycle, one pulse per request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // No answer is pending while in reset
      mask_valid <= 1'b0;
    end else begin
      // Back-to-back requests keep the strobe high
      mask_valid <= op_valid;
    end
  end

  // All checks run on the request clock; reset aborts any attempt in
  // flight, since the registers are cleared underneath it
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Alternating add/sub answers with the full arithmetic set
  a_addsub_no_divz: assert property (
    op_valid && (cls == alt_addsub_packed_double ||
                 cls == alt_addsub_packed_single)
    |=> mask_valid && flag_mask == 6'h37)
    else $error("alternating add/sub mask wrong");

  // Horizontal add/sub answers with the full arithmetic set
  a_horiz_no_divz: assert property (
    op_valid && (cls == horiz_add_packed_double ||
                 cls == horiz_add_packed_single ||
                 cls == horiz_sub_packed_double ||
                 cls == horiz_sub_packed_single)
    |=> mask_valid && flag_mask == 6'h37)
    else $error("horizontal add/sub mask wrong");

  // Loads and duplicating moves only shuffle bits
  a_moves_quiet: assert property (
    op_valid && is_move(cls) |=> flag_mask == 6'h00)
    else $error("move or load raised a flag");

  // Integer vector group never touches floating-point values
  a_intgroup_quiet: assert property (
    op_valid && cls == sfx_int_vector_group |=> flag_mask == 6'h00)
    else $error("integer group raised a flag");

  // Round result follows the immediate of the request that made it
  a_round_prec: assert property (
    mask_valid && is_round(sfx_class_t'($past(op_class)))
    |-> flag_mask == {1'b1, 4'h0, !$past(op_imm[SFX_IMM_SUPPRESS_BIT])})
    else $error("round mask ignores immediate");

  // Remaining fourth-generation operations raise nothing
  a_gen4_quiet: assert property (
    op_valid && cls == sfx_gen4_other |=> flag_mask == 6'h00)
    else $error("other fourth-generation op raised a flag");

  // Idle cycles leave the mask alone and give no strobe
  a_mask_hold: assert property (
    !op_valid |=> flag_mask == $past(flag_mask) && !mask_valid)
    else $error("mask changed without a request");

  // No class in this table can divide
  a_divz_never: assert property (
    mask_valid |-> !flag_mask[SFX_BIT_DIVZERO])
    else $error("divide-by-zero flagged by a classified op");

  // Dot product carries the arithmetic set, divide-by-zero excluded
  a_dot_arith: assert property (
    op_valid && is_dot(cls) |=> mask_valid && flag_mask == 6'h37)
    else $error("dot product mask wrong");

  // Round with the suppress bit set keeps only invalid
  a_round_quiet_prec: assert property (
    op_valid && is_round(cls) && op_imm[SFX_IMM_SUPPRESS_BIT]
    |=> flag_mask == 6'h20)
    else $error("round mask kept precision although suppressed");

  // Round with the suppress bit clear keeps invalid and precision
  a_round_open_prec: assert property (
    op_valid && is_round(cls) && !op_imm[SFX_IMM_SUPPRESS_BIT]
    |=> flag_mask == 6'h21)
    else $error("round mask lost precision");

  // Round can always report an invalid operand
  a_round_invalid: assert property (
    op_valid && is_round(cls) |=> flag_mask[SFX_BIT_INVALID])
    else $error("round mask lost invalid");

  // Codes past the last defined class raise nothing
  a_undef_quiet: assert property (
    op_valid && op_class > sfx_gen4_other |=> flag_mask == 6'h00)
    else $error("undefined class raised a flag");

  // Every accepted request yields a valid strobe one cycle later
  a_valid_follow: assert property (
    op_valid |=> mask_valid)
    else $error("request gave no valid strobe");

endmodule

// ==== hdl/sfx_pkg.sv ====
package sfx_pkg;

  // Width of the flag mask and of the class code
  localparam int SFX_FLAG_W = 6;
  localparam int SFX_CLASS_W = 5;

  // Bit positions in the flag mask, invalid first down to precision last
  localparam int SFX_BIT_INVALID = 5;
  localparam int SFX_BIT_DENORMAL = 4;
  localparam int SFX_BIT_DIVZERO = 3;
  localparam int SFX_BIT_OVERFLOW = 2;
  localparam int SFX_BIT_UNDERFLOW = 1;
  localparam int SFX_BIT_PRECISION = 0;

  // Immediate bit that suppresses precision on round-to-integral
  localparam int SFX_IMM_W = 8;
  localparam int SFX_IMM_SUPPRESS_BIT = 3;

  // Reset value of the registered flag mask
  localparam logic [5:0] SFX_MASK_RESET = 6'h00;

  // Ready-made masks
  localparam logic [5:0] SFX_MASK_NONE = 6'h00;
  localparam logic [5:0] SFX_MASK_ARITH = 6'h37;
  localparam logic [5:0] SFX_MASK_ROUND = 6'h21;
  localparam logic [5:0] SFX_MASK_PREC = 6'h01;

  // Decoded instruction classes handed over by the decoder
  typedef enum logic [4:0] {
    sfx_other_class = 5'h00,
    alt_addsub_packed_double = 5'h01,
    alt_addsub_packed_single = 5'h02,
    horiz_add_packed_double = 5'h03,
    horiz_add_packed_single = 5'h04,
    horiz_sub_packed_double = 5'h05,
    horiz_sub_packed_single = 5'h06,
    unaligned_wide_int_load = 5'h07,
    double_dup_move = 5'h08,
    single_high_dup_move = 5'h09,
    single_low_dup_move = 5'h0a,
    sfx_int_vector_group = 5'h0b,
    round_packed_double = 5'h0c,
    round_packed_single = 5'h0d,
    round_scalar_double = 5'h0e,
    round_scalar_single = 5'h0f,
    dot_product_double = 5'h10,
    dot_product_single = 5'h11,
    sfx_gen4_other = 5'h12
  } sfx_class_t;

endpackage

// ==== tb/sfx_dec_model.sv ====
`timescale 1ns/100ps
// Decoder stand-in that issues one class per cycle on the falling edge
module sfx_dec_model
  import sfx_pkg::*;
(
  sys_clk,
  req,
  req_class,
  req_imm,
  op_valid,
  op_class,
  op_imm
);
  input wire logic sys_clk;
  input wire logic req;
  input wire logic [4:0] req_class;
  input wire logic [7:0] req_imm;
  output logic op_valid = 1'b0;
  output logic [4:0] op_class = 5'h00;
  output logic [7:0] op_imm = 8'h00;
  // Idle fields flip so a stale class never looks valid
  always @(negedge sys_clk) begin
    op_valid <= req;
    op_class <= req ? req_class : ~op_class;
    op_imm <= req ? req_imm : ~op_imm;
  end
endmodule

// ==== tb/simd_fp_exception_class_tb.sv ====
`timescale 1ns/100ps
module simd_fp_exception_class_tb
  import sfx_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn;
  logic req, op_valid, mask_valid, exp_v;
  logic [4:0] req_class, op_class, exp_c;
  logic [7:0] req_imm, op_imm;
  logic [5:0] flag_mask, exp_m;
  int bad_count, tests_run, k;
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  sfx_dec_model i_dec (.sys_clk(sys_clk), .req(req), .req_class(req_class),
    .req_imm(req_imm), .op_valid(op_valid), .op_class(op_class),
    .op_imm(op_imm));
  sfx_classifier i_dut (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid),
    .op_class(op_class), .op_imm(op_imm), .mask_valid(mask_valid),
    .flag_mask(flag_mask));
  // Flags an instruction class may raise, invalid in the top bit
  function automatic logic [5:0] exp_mask(input logic [4:0] c,
    input logic [7:0] i);
    logic [5:0] m;
    m = 6'h00;
    if (c inside {[alt_addsub_packed_double:horiz_sub_packed_single],
      dot_product_double, dot_product_single}) begin
      m = 6'h3f;
      m[SFX_BIT_DIVZERO] = 1'b0;
    end
    if (c inside {[round_packed_double:round_scalar_single]}) begin
      m[SFX_BIT_INVALID] = 1'b1;
      m[SFX_BIT_PRECISION] = ~i[SFX_IMM_SUPPRESS_BIT];
    end
    return m;
  endfunction
  task automatic check(input string name, input logic [5:0] seen,
    input logic [5:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(input logic v, input logic [4:0] c, input logic [7:0] i);
    @(negedge sys_clk);
    req <= v;
    req_class <= c;
    req_imm <= i;
  endtask
  // Reference: one cycle late, mask held between requests
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      exp_v <= 1'b0;
      exp_m <= 6'h00;
      exp_c <= 5'h00;
    end else begin
      exp_v <= op_valid;
      if (op_valid) exp_m <= exp_mask(op_class, op_imm);
      if (op_valid) exp_c <= op_class;
    end
  end
  // Compare settled outputs mid-cycle
  always @(negedge sys_clk) begin
    if (rstn) begin
      check("mask_valid", {5'h00, mask_valid}, {5'h00, exp_v});
      // Round, dot product, other fourth-generation and undefined codes
      if (exp_c >= round_packed_double) begin
        check("flag_mask", flag_mask, exp_m);
      end else begin
        check("flag_mask", flag_mask, exp_m);
      end
    end
  end
  initial begin
    {bad_count, tests_run, rstn, req, req_class, req_imm} = '0;
    void'($urandom(32'h643a));
    repeat (10) @(negedge sys_clk);
    rstn <= 1'b1;
    // Every code back to back, suppress bit clear then set
    for (k = 0; k < 64; k++) send(1'b1, k[4:0], {4'h0, k[5], 3'h0});
    for (k = 0; k < 400; k++) send(1'($urandom), 5'($urandom), 8'($urandom));
    send(1'b1, round_scalar_single, 8'h00);
    rstn <= 1'b0;
    send(1'b0, 5'h00, 8'h00);
    rstn <= 1'b1;
    repeat (4) send(1'b0, 5'h00, 8'h00);
    end_sim;
  end
endmodule
